// [core/hs_switch_defines.svh]
// register map, field positions, codes and timing for the high-side switch block
`ifndef HS_SWITCH_DEFINES_SVH
`define HS_SWITCH_DEFINES_SVH

// byte addresses, one aligned 32-bit word each
`define ADDR_SRC_SELECT 8'h00
`define ADDR_SUPPLY_CFG 8'h04
`define ADDR_FAULT_STATUS 8'h08
`define ADDR_TIMER_ONE 8'h0c
`define ADDR_TIMER_TWO 8'h10
`define ADDR_PWM_BASE 8'h14
`define ADDR_WAKE_CFG 8'h24
`define ADDR_BLOCK_STATE 8'h28

// source selection codes, one 4-bit field per channel
`define SRC_OFF 4'h0
`define SRC_ON 4'h1
`define SRC_TIMER_ONE 4'h2
`define SRC_TIMER_TWO 4'h3
`define SRC_PWM_FIRST 4'h4
`define SRC_PWM_LAST 4'h7
`define SRC_SYNC 4'h8

// wake input configuration codes
`define WAKE_CFG_OFF 2'h0
`define WAKE_CFG_WAKE 2'h1
`define WAKE_CFG_SYNC 2'h2

// supply configuration fields
`define SUP_UV_DIS 0
`define SUP_UV_REC 1
`define SUP_LP_OV_DIS 2
`define SUP_OV_DIS_LSB 4
`define SUP_OV_REC_LSB 8

// fault status fields
`define FLT_OC_LSB 0
`define FLT_OL_LSB 4
`define FLT_UV 8
`define FLT_OV 9

// timer, pwm and wake fields
`define TMR_PERIOD_LSB 0
`define TMR_ON_LSB 16
`define PWM_DUTY_W 10
`define PWM_FREQ_BIT 16
`define WAKE_EDGE_BIT 8

// reset values
`define SRC_SELECT_RST 16'h0000
`define WORD16_RST 16'h0000
`define PWM_DUTY_RST 10'h000

// timing
`define CLK_MHZ 200
`define OC_FILTER_US 16
`define OC_FILTER_CYC (`OC_FILTER_US * `CLK_MHZ)
`define OL_FILTER_US 220
`define OL_FILTER_CYC (`OL_FILTER_US * `CLK_MHZ)
`define TIMER_TICK_DEFAULT 200
`define PWM_DIV_SLOW_DEFAULT 16
`define PWM_DIV_FAST_DEFAULT 4

`endif

// [core/hs_switch_pkg.sv]
// types shared by the high-side switch block and its bench
package hs_switch_pkg;

  typedef enum logic [2:0] {
    mode_normal,
    mode_stop,
    mode_sleep,
    mode_restart,
    mode_failsafe
  } mode_t;

  // analog comparator results, synchronous to pclk
  typedef struct packed {
    logic uv;
    logic ov;
    logic [3:0] oc;
    logic [3:0] ol;
  } sense_t;

  typedef struct packed {
    logic [3:0] ov_rec;
    logic [3:0] ov_dis;
    logic lp_ov_dis;
    logic uv_rec;
    logic uv_dis;
  } supply_cfg_t;

  typedef struct packed {
    logic ov;
    logic uv;
    logic [3:0] ol;
    logic [3:0] oc;
  } fault_t;

endpackage : hs_switch_pkg

// [core/high_side_switch_control.sv]
// control and protection logic for four high-side switches, apb slave
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "hs_switch_defines.svh"

module high_side_switch_control #(
  parameter int unsigned OL_FILTER_CYCLES = `OL_FILTER_CYC,
  parameter int unsigned TIMER_TICK_CYCLES = `TIMER_TICK_DEFAULT,
  parameter int unsigned PWM_DIV_SLOW = `PWM_DIV_SLOW_DEFAULT,
  parameter int unsigned PWM_DIV_FAST = `PWM_DIV_FAST_DEFAULT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output var logic [31:0] prdata,
  output var logic pready,
  output var logic pslverr,
  input wire hs_switch_pkg::mode_t device_mode,
  input wire hs_switch_pkg::sense_t sense,
  input wire logic wake4_sync_pin,
  output var logic [3:0] high_side_output,
  output var logic wake4_wake_pulse
);

  localparam logic [11:0] OC_LIMIT = 12'(`OC_FILTER_CYC);
  localparam logic [15:0] OL_LIMIT = 16'(OL_FILTER_CYCLES);
  localparam logic [15:0] TICK_TOP = 16'(TIMER_TICK_CYCLES - 1);
  localparam logic [15:0] SLOW_TOP = 16'(PWM_DIV_SLOW - 1);
  localparam logic [15:0] FAST_TOP = 16'(PWM_DIV_FAST - 1);

  function automatic logic [15:0] wrap16(input logic [15:0] cnt,
                                         input logic [15:0] top);
    wrap16 = (cnt >= top) ? 16'h0000 : cnt + 16'h0001;
  endfunction : wrap16

  function automatic logic src_level(input logic [3:0] code,
                                     input logic [1:0] tmr,
                                     input logic [3:0] pwm,
                                     input logic sync);
    src_level = 1'b0;
    if (code == `SRC_ON) begin
      src_level = 1'b1;
    end else if (code == `SRC_TIMER_ONE) begin
      src_level = tmr[0];
    end else if (code == `SRC_TIMER_TWO) begin
      src_level = tmr[1];
    end else if (code >= `SRC_PWM_FIRST && code <= `SRC_PWM_LAST) begin
      src_level = pwm[code[1:0]];
    end else if (code == `SRC_SYNC) begin
      src_level = sync;
    end
  endfunction : src_level

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [15:0] src_sel_reg;
  logic [15:0] src_sel_next;
  hs_switch_pkg::supply_cfg_t supply_cfg_reg;
  hs_switch_pkg::fault_t fault_reg;
  hs_switch_pkg::fault_t fault_next;
  logic [15:0] tmr_period_reg [2];
  logic [15:0] tmr_on_reg [2];
  logic [15:0] tmr_cnt_reg [2];
  logic [9:0] pwm_duty_reg [4];
  logic [9:0] pwm_cnt_reg [4];
  logic [3:0] pwm_fast_reg;
  logic [1:0] wake_cfg_reg;
  logic wake_edge_reg;
  logic pin_d_reg;
  logic [15:0] tick_cnt_reg;
  logic [15:0] slow_cnt_reg;
  logic [15:0] fast_cnt_reg;
  logic [3:0] uv_shut_reg;
  logic [3:0] uv_shut_next;
  logic [3:0] ov_shut_reg;
  logic [3:0] ov_shut_next;
  logic [11:0] oc_cnt_reg [4];
  logic [15:0] ol_cnt_reg [4];
  logic [3:0] out_next;
  logic [31:0] rd_word;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  wire setup = psel & ~penable;
  wire access = psel & penable & pready;
  wire hit_src = paddr == `ADDR_SRC_SELECT;
  wire hit_sup = paddr == `ADDR_SUPPLY_CFG;
  wire hit_flt = paddr == `ADDR_FAULT_STATUS;
  wire hit_t1 = paddr == `ADDR_TIMER_ONE;
  wire hit_t2 = paddr == `ADDR_TIMER_TWO;
  wire hit_wake = paddr == `ADDR_WAKE_CFG;
  wire hit_state = paddr == `ADDR_BLOCK_STATE;
  wire [3:0] hit_pwm;
  for (genvar n = 0; n < 4; n++) begin : g_pwm_hit
    assign hit_pwm[n] = paddr == (`ADDR_PWM_BASE + 8'(4 * n));
  end
  wire cfg_hit = hit_src | hit_sup | hit_t1 | hit_t2 | hit_wake | (|hit_pwm);
  wire mapped = cfg_hit | hit_flt | hit_state;
  wire mode_normal = device_mode == hs_switch_pkg::mode_normal;
  wire mode_off = device_mode == hs_switch_pkg::mode_restart ||
                  device_mode == hs_switch_pkg::mode_failsafe;
  // locked configuration answers with an error so software sees the refusal
  wire reject = pwrite & cfg_hit & ~mode_normal;
  wire setup_err = ~mapped | reject;
  wire wr_ok = access & pwrite & ~pslverr;
  wire wr_src = wr_ok & hit_src;
  wire [31:0] flt_clr = (wr_ok & hit_flt) ? pwdata : 32'h0000_0000;

  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit_src) begin
      rd_word = {16'h0000, src_sel_reg};
    end else if (hit_sup) begin
      rd_word = {20'h00000, supply_cfg_reg.ov_rec, supply_cfg_reg.ov_dis,
                 1'b0, supply_cfg_reg.lp_ov_dis, supply_cfg_reg.uv_rec,
                 supply_cfg_reg.uv_dis};
    end else if (hit_flt) begin
      rd_word = {22'h000000, fault_reg};
    end else if (hit_t1) begin
      rd_word = {tmr_on_reg[0], tmr_period_reg[0]};
    end else if (hit_t2) begin
      rd_word = {tmr_on_reg[1], tmr_period_reg[1]};
    end else if (hit_wake) begin
      rd_word = {23'h000000, wake_edge_reg, 6'h00, wake_cfg_reg};
    end else if (hit_state) begin
      rd_word = {16'h0000, ov_shut_reg, uv_shut_reg, high_side_output,
                 1'b0, 3'(device_mode)};
    end else begin
      for (int n = 0; n < 4; n++) begin
        if (hit_pwm[n]) begin
          rd_word = {15'h0000, pwm_fast_reg[n], 6'h00, pwm_duty_reg[n]};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timers, pwm generators, sync

  wire tick = tick_cnt_reg == TICK_TOP;
  wire slow_tick = slow_cnt_reg == SLOW_TOP;
  wire fast_tick = fast_cnt_reg == FAST_TOP;
  wire [1:0] tmr_level;
  wire [3:0] pwm_level;
  for (genvar t = 0; t < 2; t++) begin : g_tmr
    assign tmr_level[t] = tmr_cnt_reg[t] < tmr_on_reg[t];
  end
  for (genvar n = 0; n < 4; n++) begin : g_pwm
    assign pwm_level[n] = pwm_cnt_reg[n] < pwm_duty_reg[n];
  end
  wire sync_mode = wake_cfg_reg == `WAKE_CFG_SYNC;
  wire sync_level = wake4_sync_pin & sync_mode;
  // the edge bit only matters in wake mode; sync mode never wakes
  wire wake_edge = wake_edge_reg ? (wake4_sync_pin & ~pin_d_reg)
                                 : (~wake4_sync_pin & pin_d_reg);
  wire wake_hit = (wake_cfg_reg == `WAKE_CFG_WAKE) & wake_edge;

  ////////////////////////////////////////////////////////////////////////////
  // per-channel protection and drive

  wire [3:0] oc_trip;
  wire [3:0] ol_trip;
  for (genvar i = 0; i < 4; i++) begin : g_ch
    wire [3:0] cur = src_sel_reg[4*i +: 4];
    wire [3:0] wr_code = pwdata[4*i +: 4];
    wire code_ok = (wr_code <= `SRC_PWM_LAST) |
                   ((wr_code == `SRC_SYNC) & sync_mode);
    wire ch_on = cur != `SRC_OFF;
    wire uv_hit = sense.uv & ~supply_cfg_reg.uv_dis & ch_on;
    wire ov_keep = mode_normal ? supply_cfg_reg.ov_dis[i]
                               : supply_cfg_reg.lp_ov_dis;
    wire ov_hit = sense.ov & ~ov_keep & ch_on;
    wire uv_rel = uv_shut_reg[i] & ~sense.uv;
    wire ov_rel = ov_shut_reg[i] & ~sense.ov;
    wire hw_clear = oc_trip[i] | mode_off |
                    (uv_rel & ~supply_cfg_reg.uv_rec) |
                    (ov_rel & ~supply_cfg_reg.ov_rec[i]);
    assign oc_trip[i] = oc_cnt_reg[i] == OC_LIMIT;
    assign ol_trip[i] = ol_cnt_reg[i] == OL_LIMIT;
    // a hardware clear beats a software write in the same cycle
    assign src_sel_next[4*i +: 4] = hw_clear ? `SRC_OFF :
                                    (wr_src & code_ok) ? wr_code : cur;
    assign uv_shut_next[i] = ~mode_off &
                             (uv_hit | (uv_shut_reg[i] & sense.uv));
    assign ov_shut_next[i] = ~mode_off &
                             (ov_hit | (ov_shut_reg[i] & sense.ov));
    assign out_next[i] = src_level(cur, tmr_level, pwm_level, sync_level) &
                         ~uv_hit & ~ov_hit & ~uv_shut_reg[i] &
                         ~ov_shut_reg[i] & ~oc_trip[i] &
                         ~mode_off;
  end

  // sticky flags, a new event wins over a clear in the same cycle
  assign fault_next.oc = (fault_reg.oc & ~flt_clr[`FLT_OC_LSB +: 4]) |
                         oc_trip;
  assign fault_next.ol = (fault_reg.ol & ~flt_clr[`FLT_OL_LSB +: 4]) |
                         ol_trip;
  assign fault_next.uv = (fault_reg.uv & ~flt_clr[`FLT_UV]) | sense.uv;
  assign fault_next.ov = (fault_reg.ov & ~flt_clr[`FLT_OV]) | sense.ov;

  ////////////////////////////////////////////////////////////////////////////
  // apb response

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      // error only stands beside ready, never left over from a refusal
      pslverr <= setup & setup_err;
      if (setup) begin
        prdata <= (pwrite | ~mapped) ? 32'h0000_0000 : rd_word;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_sel_reg <= `SRC_SELECT_RST;
      supply_cfg_reg <= '0;
      fault_reg <= '0;
      wake_cfg_reg <= `WAKE_CFG_OFF;
      wake_edge_reg <= 1'b0;
    end else begin
      src_sel_reg <= src_sel_next;
      fault_reg <= fault_next;
      if (wr_ok & hit_sup) begin
        supply_cfg_reg.uv_dis <= pwdata[`SUP_UV_DIS];
        supply_cfg_reg.uv_rec <= pwdata[`SUP_UV_REC];
        supply_cfg_reg.lp_ov_dis <= pwdata[`SUP_LP_OV_DIS];
        supply_cfg_reg.ov_dis <= pwdata[`SUP_OV_DIS_LSB +: 4];
        supply_cfg_reg.ov_rec <= pwdata[`SUP_OV_REC_LSB +: 4];
      end
      if (wr_ok & hit_wake) begin
        wake_cfg_reg <= pwdata[1:0];
        wake_edge_reg <= pwdata[`WAKE_EDGE_BIT];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int t = 0; t < 2; t++) begin
        tmr_period_reg[t] <= `WORD16_RST;
        tmr_on_reg[t] <= `WORD16_RST;
      end
      for (int n = 0; n < 4; n++) begin
        pwm_duty_reg[n] <= `PWM_DUTY_RST;
      end
      pwm_fast_reg <= 4'h0;
    end else begin
      if (wr_ok & hit_t1) begin
        tmr_period_reg[0] <= pwdata[`TMR_PERIOD_LSB +: 16];
        tmr_on_reg[0] <= pwdata[`TMR_ON_LSB +: 16];
      end
      if (wr_ok & hit_t2) begin
        tmr_period_reg[1] <= pwdata[`TMR_PERIOD_LSB +: 16];
        tmr_on_reg[1] <= pwdata[`TMR_ON_LSB +: 16];
      end
      for (int n = 0; n < 4; n++) begin
        if (wr_ok & hit_pwm[n]) begin
          pwm_duty_reg[n] <= pwdata[`PWM_DUTY_W-1:0];
          pwm_fast_reg[n] <= pwdata[`PWM_FREQ_BIT];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counters

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_reg <= `WORD16_RST;
      slow_cnt_reg <= `WORD16_RST;
      fast_cnt_reg <= `WORD16_RST;
      for (int t = 0; t < 2; t++) begin
        tmr_cnt_reg[t] <= `WORD16_RST;
      end
      for (int n = 0; n < 4; n++) begin
        pwm_cnt_reg[n] <= `PWM_DUTY_RST;
      end
    end else begin
      tick_cnt_reg <= wrap16(tick_cnt_reg, TICK_TOP);
      slow_cnt_reg <= wrap16(slow_cnt_reg, SLOW_TOP);
      fast_cnt_reg <= wrap16(fast_cnt_reg, FAST_TOP);
      for (int t = 0; t < 2; t++) begin
        if (tick) begin
          tmr_cnt_reg[t] <= wrap16(tmr_cnt_reg[t],
                                   tmr_period_reg[t] - 16'h0001);
        end
      end
      for (int n = 0; n < 4; n++) begin
        if (pwm_fast_reg[n] ? fast_tick : slow_tick) begin
          pwm_cnt_reg[n] <= pwm_cnt_reg[n] + 10'h001;
        end
      end
    end
  end

  // filters restart whenever the output goes off, so a pwm channel with
  // short on phases never reaches the open-load time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        oc_cnt_reg[i] <= 12'h000;
        ol_cnt_reg[i] <= `WORD16_RST;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (sense.oc[i] & high_side_output[i] & ~oc_trip[i]) begin
          oc_cnt_reg[i] <= oc_cnt_reg[i] + 12'h001;
        end else begin
          oc_cnt_reg[i] <= 12'h000;
        end
        if (sense.ol[i] & high_side_output[i]) begin
          if (!ol_trip[i]) begin
            ol_cnt_reg[i] <= ol_cnt_reg[i] + 16'h0001;
          end
        end else begin
          ol_cnt_reg[i] <= `WORD16_RST;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs and shutdown state

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uv_shut_reg <= 4'h0;
      ov_shut_reg <= 4'h0;
      high_side_output <= 4'h0;
      pin_d_reg <= 1'b0;
      wake4_wake_pulse <= 1'b0;
    end else begin
      uv_shut_reg <= uv_shut_next;
      ov_shut_reg <= ov_shut_next;
      high_side_output <= out_next;
      pin_d_reg <= wake4_sync_pin;
      wake4_wake_pulse <= wake_hit;
    end
  end

endmodule : high_side_switch_control

`default_nettype wire

// [bench/led_load_model.sv]
// loads hanging on the four high-side outputs
`timescale 1ns/1ps
`default_nettype none
module led_load_model (
  input wire logic [3:0] high_side_output,
  input wire logic [3:0] shorted,
  input wire logic [3:0] opened,
  output var logic [3:0] oc,
  output var logic [3:0] ol
);
  // an off switch carries no current, so the low-current comparator
  // reads high then; the block must not flag that
  assign oc = high_side_output & shorted;
  assign ol = ~high_side_output | opened;
endmodule : led_load_model
`default_nettype wire

// [bench/hs_switch_asserts.sv]
// port checker for the high-side switch block
`timescale 1ns/1ps
`default_nettype none
module hs_switch_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire hs_switch_pkg::mode_t device_mode,
  input wire hs_switch_pkg::sense_t sense,
  input wire logic [3:0] high_side_output,
  input wire logic wake4_wake_pulse
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [12:0] oc_cnt;
  wire oc_hot = sense.oc[0] && high_side_output[0];
  wire bad = paddr > 8'h28 || paddr[1:0] != 2'h0;
  wire down = device_mode == hs_switch_pkg::mode_restart ||
    device_mode == hs_switch_pkg::mode_failsafe;
  wire locked = device_mode != hs_switch_pkg::mode_normal;
  ////////////////////////////////////////////////////////////////////////
  // the filter is fixed, so an on channel must trip close to 3200 cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oc_cnt <= 13'h0;
    end else begin
      oc_cnt <= oc_hot ? oc_cnt + 13'h1 : 13'h0;
    end
  end
  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence down_then_idle;
    down ##1 (!down && !psel) [*2];
  endsequence
  ////////////////////////////////////////////////////////////////////////
  ready_after_setup_a: assert property (apb_setup |=> pready)
    else $error("no ready after setup");
  ready_single_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  unmapped_err_a: assert property (apb_setup and bad |=>
    pslverr && prdata == 32'h0) else $error("unmapped not refused");
  config_lock_a: assert property (
    apb_setup and pwrite && locked && paddr != 8'h08 && paddr != 8'h28
    |=> pslverr) else $error("locked write accepted");
  restart_off_a: assert property (down |=> high_side_output == 4'h0)
    else $error("output on in restart");
  restart_clear_a: assert property (
    down_then_idle |-> high_side_output == 4'h0)
    else $error("output back after restart");
  oc_trip_a: assert property (oc_cnt <= 13'hc82)
    else $error("overcurrent not tripped");
  wake_pulse_a: assert property (wake4_wake_pulse |=> !wake4_wake_pulse)
    else $error("wake pulse too long");
endmodule : hs_switch_asserts
bind high_side_switch_control hs_switch_asserts chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .device_mode(device_mode), .sense(sense),
  .high_side_output(high_side_output), .wake4_wake_pulse(wake4_wake_pulse));
`default_nettype wire

// [bench/high_side_switch_control_tb.sv]
// self-checking bench for the high-side switch control block
`timescale 1ns/1ps
`default_nettype none
module high_side_switch_control_tb;
  typedef struct {
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] q;
    logic e;
  } row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  hs_switch_pkg::mode_t device_mode = hs_switch_pkg::mode_normal;
  hs_switch_pkg::sense_t sense;
  logic uv = 1'b0;
  logic ov = 1'b0;
  logic [3:0] oc;
  logic [3:0] ol;
  logic [3:0] shorted = 4'h0;
  logic [3:0] opened = 4'h0;
  logic wake4_sync_pin = 1'b0;
  logic [3:0] high_side_output;
  logic wake4_wake_pulse;
  logic seen = 1'b0;
  int err_count = 0;
  int n_compared = 0;
  int hi [4];
  int n;
  row_t rows [9] = '{
    '{8'h00, 32'h0000_8000, 32'h0, 1'b0},
    '{8'h14, 32'h0001_0200, 32'h0001_0200, 1'b0},
    '{8'h18, 32'h0000_03ff, 32'h0000_03ff, 1'b0},
    '{8'h0c, 32'h0002_0004, 32'h0002_0004, 1'b0},
    '{8'h10, 32'h0003_0008, 32'h0003_0008, 1'b0},
    '{8'h24, 32'h0000_0102, 32'h0000_0102, 1'b0},
    '{8'h00, 32'h0000_8624, 32'h0000_8624, 1'b0},
    '{8'h2c, 32'hffff_ffff, 32'h0, 1'b1},
    '{8'h08, 32'h0000_03ff, 32'h0, 1'b0}
  };
  assign sense = {uv, ov, oc, ol};
  high_side_switch_control #(.OL_FILTER_CYCLES(20), .TIMER_TICK_CYCLES(2),
    .PWM_DIV_SLOW(2), .PWM_DIV_FAST(1)) DUT (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .device_mode(device_mode), .sense(sense),
    .wake4_sync_pin(wake4_sync_pin), .high_side_output(high_side_output),
    .wake4_wake_pulse(wake4_wake_pulse));
  led_load_model loads (.high_side_output(high_side_output),
    .shorted(shorted), .opened(opened), .oc(oc), .ol(ol));
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (wake4_wake_pulse === 1'b1) begin
      seen <= 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic ok(input logic c);
    check({31'h0, c}, 32'h1);
  endtask : ok
  task automatic out(input logic [3:0] e);
    check({28'h0, high_side_output}, {28'h0, e});
  endtask : out
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask : cyc
  // outputs are read right after the edge, before its updates land
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    int t;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    ok(t < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    logic [31:0] r;
    logic er;
    apb(1'b1, a, d, r, er);
    ok(er === e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] q, input logic e);
    logic [31:0] r;
    logic er;
    apb(1'b0, a, 32'h0, r, er);
    check(r, q);
    ok(er === e);
  endtask : rd
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #300000;
    err_count++;
    final_report();
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = 0; a <= 40; a += 4) begin
      rd(a[7:0], 32'h0, 1'b0);
    end
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, rows[i].e);
      rd(rows[i].a, rows[i].q, rows[i].e);
    end
    hi = '{0, 0, 0, 0};
    repeat (6000) begin
      @(posedge pclk);
      foreach (hi[i]) begin
        hi[i] += int'(high_side_output[i]);
      end
    end
    ok(hi[0] > 0 && hi[0] < 6000);
    ok(hi[1] > 2950 && hi[1] < 3050);
    ok(hi[2] == 0 && hi[3] == 0);
    wake4_sync_pin <= 1'b1;
    cyc(3);
    ok(high_side_output[3]);
    wake4_sync_pin <= 1'b0;
    cyc(3);
    ok(!high_side_output[3] && !seen);
    wr(8'h24, 32'h0000_0101, 1'b0);
    wake4_sync_pin <= 1'b1;
    cyc(4);
    ok(seen);
    // the three supply settings: plain, shutdown disabled, recovery
    for (int k = 0; k < 3; k++) begin
      wr(8'h04, k, 1'b0);
      wr(8'h00, 32'h0000_1111, 1'b0);
      uv <= 1'b1;
      cyc(3);
      out(k == 1 ? 4'hf : 4'h0);
      uv <= 1'b0;
      cyc(3);
      out(k == 0 ? 4'h0 : 4'hf);
      rd(8'h00, k == 0 ? 32'h0 : 32'h0000_1111, 1'b0);
    end
    rd(8'h08, 32'h0000_0100, 1'b0);
    wr(8'h08, 32'h0000_0100, 1'b0);
    wr(8'h04, 32'h0000_02c0, 1'b0);
    wr(8'h00, 32'h0000_1111, 1'b0);
    ov <= 1'b1;
    cyc(3);
    out(4'hc);
    ov <= 1'b0;
    cyc(3);
    out(4'he);
    rd(8'h00, 32'h0000_1110, 1'b0);
    rd(8'h08, 32'h0000_0200, 1'b0);
    wr(8'h04, 32'h0000_0004, 1'b0);
    wr(8'h00, 32'h0000_1111, 1'b0);
    device_mode <= hs_switch_pkg::mode_stop;
    cyc(2);
    wr(8'h00, 32'h0, 1'b1);
    wr(8'h04, 32'h0, 1'b1);
    rd(8'h00, 32'h0000_1111, 1'b0);
    rd(8'h28, 32'h0000_00f1, 1'b0);
    device_mode <= hs_switch_pkg::mode_sleep;
    ov <= 1'b1;
    cyc(3);
    out(4'hf);
    ov <= 1'b0;
    device_mode <= hs_switch_pkg::mode_restart;
    cyc(3);
    out(4'h0);
    device_mode <= hs_switch_pkg::mode_normal;
    cyc(2);
    rd(8'h00, 32'h0, 1'b0);
    wr(8'h00, 32'h0000_1111, 1'b0);
    device_mode <= hs_switch_pkg::mode_failsafe;
    cyc(3);
    out(4'h0);
    device_mode <= hs_switch_pkg::mode_normal;
    cyc(2);
    rd(8'h00, 32'h0, 1'b0); // failsafe
    wr(8'h08, 32'h0000_03ff, 1'b0);
    shorted <= 4'h1;
    wr(8'h00, 32'h0000_0001, 1'b0);
    cyc(2);
    n = 0;
    while (high_side_output[0] === 1'b1 && n < 4000) begin
      @(posedge pclk);
      n++;
    end
    ok(n > 3190 && n < 3210);
    shorted <= 4'h0;
    rd(8'h00, 32'h0, 1'b0);
    cyc(50);
    rd(8'h08, 32'h0000_0001, 1'b0);
    wr(8'h00, 32'h0000_0001, 1'b0);
    cyc(2);
    out(4'h1);
    wr(8'h08, 32'h0000_0001, 1'b0);
    rd(8'h08, 32'h0, 1'b0);
    opened <= 4'h2;
    wr(8'h00, 32'h0000_0010, 1'b0);
    cyc(40);
    out(4'h2);
    opened <= 4'h0;
    cyc(40);
    rd(8'h08, 32'h0000_0020, 1'b0);
    wr(8'h08, 32'h0000_0020, 1'b0);
    rd(8'h08, 32'h0, 1'b0);
    final_report();
  end
endmodule : high_side_switch_control_tb
`default_nettype wire
